// file: rtl/fbep_consts.svh
// constants for the flash block erase protect unit
`ifndef FBEP_CONSTS_SVH
`define FBEP_CONSTS_SVH
`define FBEP_ADDR_W     17
`define FBEP_ERASE_W    7
`define FBEP_PROT_W     6
`define FBEP_NUM_PROT   64
`define FBEP_ERASE_LSB  10
`define FBEP_PROT_LSB   11
`define FBEP_DATA_W     32
`define FBEP_ERASED_WORD 32'hFFFFFFFF
`endif

// file: rtl/fbep_guard.sv
// access and erase gatekeeper in front of the flash array
// Behaviour
// - the 128 KB array is split into 1 KB erase units, each erasable alone.
// - an allowed erase drives every bit of the unit to one.
// - protection is per 2 KB unit of two adjacent erase units, set independently.
// - a read-only unit refuses every erase and program request.
// - an execute-only unit refuses every erase and program request.
// - an execute-only unit admits instruction fetch only, denying data and debug reads.
`include "fbep_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module fbep_guard (
	// clock and reset
	input  wire logic                          clk,
	input  wire logic                          rst,
	// protection bits per 2 KB unit
	input  wire logic [`FBEP_NUM_PROT-1:0]     ro_bits,
	input  wire logic [`FBEP_NUM_PROT-1:0]     xo_bits,
	// request from fetch, data or debug path
	input  wire logic                          req_valid,
	input  wire fbep_pkg::fbep_req_type        req,
	// answer, one cycle after the request
	output var  fbep_pkg::fbep_rsp_type        rsp,
	output logic                               rsp_valid,
	// flash array side
	output logic                               arr_erase,
	output logic [`FBEP_ERASE_W-1:0]           arr_erase_unit,
	output logic                               arr_prog,
	output logic [`FBEP_ADDR_W-1:0]            arr_addr,
	output logic [`FBEP_DATA_W-1:0]            arr_wdata,
	input  wire logic [`FBEP_DATA_W-1:0]       arr_rdata
);
	// request decode
	wire logic [`FBEP_PROT_W-1:0]   prot_idx;
	wire logic [`FBEP_ERASE_W-1:0]  erase_idx;
	wire logic [`FBEP_NUM_PROT-1:0] unit_hit;
	wire logic [`FBEP_NUM_PROT-1:0] ro_hit;
	wire logic [`FBEP_NUM_PROT-1:0] xo_hit;
	wire fbep_pkg::fbep_prot_type   prot_sel;
	wire logic                      is_fetch;
	wire logic                      is_dread;
	wire logic                      is_dbgread;
	wire logic                      is_erase;
	wire logic                      is_prog;
	wire logic                      is_read;
	wire logic                      is_modify;
	wire logic                      modify_ok;
	wire logic                      read_ok;
	wire logic                      allow;

	assign prot_idx  = req.addr[`FBEP_ADDR_W-1:`FBEP_PROT_LSB];
	assign erase_idx = req.addr[`FBEP_ADDR_W-1:`FBEP_ERASE_LSB];

	for (genvar k = 0; k < `FBEP_NUM_PROT; k++) begin : g_unit
		assign unit_hit[k] = prot_idx == (`FBEP_PROT_W)'(k);
		assign ro_hit[k]   = unit_hit[k] && ro_bits[k];
		assign xo_hit[k]   = unit_hit[k] && xo_bits[k];
	end

	// hits are one-hot, so an or-reduction picks the addressed unit's flags
	assign prot_sel   = '{ro: |ro_hit, xo: |xo_hit};
	assign is_fetch   = req.op == fbep_pkg::FBEP_OP_FETCH;
	assign is_dread   = req.op == fbep_pkg::FBEP_OP_DREAD;
	assign is_dbgread = req.op == fbep_pkg::FBEP_OP_DBGREAD;
	assign is_erase   = req.op == fbep_pkg::FBEP_OP_ERASE;
	assign is_prog    = req.op == fbep_pkg::FBEP_OP_PROG;
	assign is_read    = is_fetch || is_dread || is_dbgread;
	assign is_modify  = is_erase || is_prog;
	// erase and program need a unit with neither flag
	assign modify_ok  = is_modify && !prot_sel.ro && !prot_sel.xo;
	// exec-only admits fetch alone; read-only leaves reads open
	assign read_ok    = is_read && (!prot_sel.xo || is_fetch);
	// unused opcodes fall through to a refusal
	assign allow      = modify_ok || read_ok;

	// registered state and its next values
	logic                      rsp_valid_r;
	logic                      allow_r;
	logic                      rd_pend_r;
	logic                      erase_r;
	logic                      prog_r;
	logic [`FBEP_ERASE_W-1:0]  erase_unit_r;
	logic [`FBEP_ADDR_W-1:0]   addr_r;
	logic [`FBEP_DATA_W-1:0]   wdata_r;
	wire logic                 rd_pend_nxt;
	wire logic                 erase_nxt;
	wire logic                 prog_nxt;

	assign rd_pend_nxt = req_valid && read_ok;
	assign erase_nxt   = req_valid && modify_ok && is_erase;
	assign prog_nxt    = req_valid && modify_ok && is_prog;

	// answer state
	always_ff @(posedge clk) begin
		if (rst) begin
			rsp_valid_r <= 1'h0;
			allow_r     <= 1'h0;
			rd_pend_r   <= 1'h0;
		end else begin
			rsp_valid_r <= req_valid;
			allow_r     <= allow;
			rd_pend_r   <= rd_pend_nxt;
		end
	end

	always_ff @(posedge clk) begin
		if (rst) begin
			erase_r <= 1'h0;
			prog_r  <= 1'h0;
		end else begin
			erase_r <= erase_nxt;
			prog_r  <= prog_nxt;
		end
	end

	// address and data cleared in reset so the array sees a quiet bus
	always_ff @(posedge clk) begin
		if (rst) begin
			erase_unit_r <= '0;
			addr_r       <= '0;
			wdata_r      <= '0;
		end else begin
			erase_unit_r <= erase_idx;
			addr_r       <= req.addr;
			wdata_r      <= req.wdata;
		end
	end

	assign rsp_valid      = rsp_valid_r;
	assign arr_erase      = erase_r;
	assign arr_prog       = prog_r;
	assign arr_erase_unit = erase_unit_r;
	assign arr_addr       = addr_r;
	assign arr_wdata      = wdata_r;

	wire logic                    rsp_grant;
	wire logic                    rsp_deny;
	wire logic [`FBEP_DATA_W-1:0] rsp_rdata;
	// denied reads return zero so protected code never leaks
	assign rsp_grant = rsp_valid_r && allow_r;
	assign rsp_deny  = rsp_valid_r && !allow_r;
	assign rsp_rdata = rd_pend_r ? arr_rdata : '0;
	assign rsp       = '{grant: rsp_grant, deny: rsp_deny, rdata: rsp_rdata};

	property p_xo_data_denied;
		@(posedge clk) disable iff (rst)
		req_valid && xo_bits[prot_idx] && !is_fetch |=> rsp.deny;
	endproperty
	a_xo_data_denied: assert property (p_xo_data_denied) else $error("exec-only non-fetch not denied");

	property p_ro_no_modify;
		@(posedge clk) disable iff (rst)
		req_valid && ro_bits[prot_idx] && is_modify |=> !arr_erase && !arr_prog && rsp.deny;
	endproperty
	a_ro_no_modify: assert property (p_ro_no_modify) else $error("read-only unit modified");

	property p_xo_no_modify;
		@(posedge clk) disable iff (rst)
		req_valid && xo_bits[prot_idx] && is_modify |=> !arr_erase && !arr_prog;
	endproperty
	a_xo_no_modify: assert property (p_xo_no_modify) else $error("exec-only unit modified");

	property p_free_grant;
		@(posedge clk) disable iff (rst)
		req_valid && !ro_bits[prot_idx] && !xo_bits[prot_idx] |=> rsp.grant;
	endproperty
	a_free_grant: assert property (p_free_grant) else $error("unrestricted access refused");

	property p_fetch_ok;
		@(posedge clk) disable iff (rst)
		req_valid && is_fetch |=> rsp.grant;
	endproperty
	a_fetch_ok: assert property (p_fetch_ok) else $error("fetch refused");

	property p_erase_unit;
		@(posedge clk) disable iff (rst)
		req_valid && is_erase && !ro_bits[prot_idx] && !xo_bits[prot_idx]
		|=> arr_erase && arr_erase_unit == $past(req.addr[`FBEP_ADDR_W-1:`FBEP_ERASE_LSB]);
	endproperty
	a_erase_unit: assert property (p_erase_unit) else $error("erase unit wrong");

	property p_erase_only_on_req;
		@(posedge clk) disable iff (rst)
		arr_erase |-> $past(req_valid) && rsp.grant;
	endproperty
	a_erase_only_on_req: assert property (p_erase_only_on_req) else $error("spurious erase");

	// the decoder must agree with a direct index by erase unit pair
	property p_pair_shared;
		@(posedge clk) disable iff (rst)
		req_valid |-> prot_sel.ro == ro_bits[erase_idx[`FBEP_ERASE_W-1:1]] &&
		              prot_sel.xo == xo_bits[erase_idx[`FBEP_ERASE_W-1:1]];
	endproperty
	a_pair_shared: assert property (p_pair_shared) else $error("protection pairing wrong");

	property p_deny_zero;
		@(posedge clk) disable iff (rst)
		rsp.deny |-> rsp.rdata == 32'h00000000;
	endproperty
	a_deny_zero: assert property (p_deny_zero) else $error("denied read leaked data");

	property p_one_answer;
		@(posedge clk) disable iff (rst)
		req_valid |=> rsp_valid && (rsp.grant != rsp.deny);
	endproperty
	a_one_answer: assert property (p_one_answer) else $error("answer missing or ambiguous");

	property p_prog_target;
		@(posedge clk) disable iff (rst)
		req_valid && is_prog && !ro_bits[prot_idx] && !xo_bits[prot_idx]
		|=> arr_prog && arr_addr == $past(req.addr) && arr_wdata == $past(req.wdata);
	endproperty
	a_prog_target: assert property (p_prog_target) else $error("program target wrong");

	property p_fetch_data;
		@(posedge clk) disable iff (rst)
		req_valid && is_fetch |=> rsp.rdata == arr_rdata;
	endproperty
	a_fetch_data: assert property (p_fetch_data) else $error("fetch data blocked");

	property p_dbg_free;
		@(posedge clk) disable iff (rst)
		req_valid && is_dbgread && !xo_bits[prot_idx] |=> rsp.grant;
	endproperty
	a_dbg_free: assert property (p_dbg_free) else $error("debug read refused");

	property p_idle_quiet;
		@(posedge clk) disable iff (rst)
		!req_valid |=> !arr_erase && !arr_prog;
	endproperty
	a_idle_quiet: assert property (p_idle_quiet) else $error("strobe without request");

	c_xo_fetch: cover property (@(posedge clk) disable iff (rst) req_valid && is_fetch && xo_bits[prot_idx]);
	c_dbg_deny: cover property (@(posedge clk) disable iff (rst)
		req_valid && is_dbgread && xo_bits[prot_idx]);
	c_erase_ok: cover property (@(posedge clk) disable iff (rst) arr_erase);
	c_prog_deny: cover property (@(posedge clk) disable iff (rst)
		req_valid && is_prog && ro_bits[prot_idx]);
	c_ro_read: cover property (@(posedge clk) disable iff (rst) req_valid && is_dread && ro_bits[prot_idx]);
endmodule : fbep_guard
`default_nettype wire

// file: rtl/fbep_pkg.sv
// types for the flash block erase protect unit
package fbep_pkg;
	typedef enum logic [2:0] {
		FBEP_OP_FETCH,
		FBEP_OP_DREAD,
		FBEP_OP_DBGREAD,
		FBEP_OP_ERASE,
		FBEP_OP_PROG
	} fbep_op_type;

	typedef struct packed {
		fbep_op_type op;
		logic [16:0] addr;
		logic [31:0] wdata;
	} fbep_req_type;

	typedef struct packed {
		logic        grant;
		logic        deny;
		logic [31:0] rdata;
	} fbep_rsp_type;

	typedef struct packed {
		logic ro;
		logic xo;
	} fbep_prot_type;
endpackage : fbep_pkg

// file: tb/fbep_array_model.sv
// behavioural flash array behind the guard
`timescale 1ns/1ps
`default_nettype none
module fbep_array_model (
	// clock
	input  wire logic        clk,
	// array side
	input  wire logic        erase,
	input  wire logic [6:0]  unit,
	input  wire logic        prog,
	input  wire logic [16:0] addr,
	input  wire logic [31:0] wdata,
	output logic      [31:0] rdata
);
	logic [31:0] mem [0:32767];
	// preload word index so unerased words differ from ones
	initial for (int i = 0; i < 32768; i++) mem[i] = i;
	assign rdata = mem[addr[16:2]];
	always @(posedge clk) begin
		if (erase) for (int i = 0; i < 256; i++) mem[{unit, 8'h00} + 15'(i)] <= 32'hFFFFFFFF;
		if (prog) mem[addr[16:2]] <= wdata;
	end
endmodule : fbep_array_model
`default_nettype wire

// file: tb/testbench.sv
// self-checking bench for the flash guard
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin n_checks++; if ((a) !== (e)) begin n_errors++; $display("mismatch %s exp %h got %h", n, e, a); end end
module testbench;
	logic                   clk = 0, rst = 1, req_valid = 0;
	logic [63:0]            ro_bits = '0, xo_bits = '0;
	fbep_pkg::fbep_req_type req = '0;
	fbep_pkg::fbep_rsp_type rsp;
	logic                   rsp_valid, arr_erase, arr_prog;
	logic [6:0]             arr_erase_unit;
	logic [16:0]            arr_addr;
	logic [31:0]            arr_wdata, arr_rdata;
	int                     n_errors = 0, n_checks = 0;
	fbep_guard fbep_guard_inst (.clk(clk), .rst(rst), .ro_bits(ro_bits), .xo_bits(xo_bits),
		.req_valid(req_valid), .req(req), .rsp(rsp), .rsp_valid(rsp_valid), .arr_erase(arr_erase),
		.arr_erase_unit(arr_erase_unit), .arr_prog(arr_prog), .arr_addr(arr_addr),
		.arr_wdata(arr_wdata), .arr_rdata(arr_rdata));
	fbep_array_model fbep_array_model_inst (.clk(clk), .erase(arr_erase), .unit(arr_erase_unit),
		.prog(arr_prog), .addr(arr_addr), .wdata(arr_wdata), .rdata(arr_rdata));
	initial forever #2.5 clk = ~clk;
	// one request, answer judged in the cycle after it is taken
	task automatic acc(input fbep_pkg::fbep_op_type o, input logic [16:0] a, input logic [31:0] w,
			input logic g, input logic [31:0] d);
		@(posedge clk);
		req_valid <= 1'b1;
		req <= '{op: o, addr: a, wdata: w};
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		`CHK("rsp_valid", 1'b1, rsp_valid)
		`CHK("grant", g, rsp.grant)
		`CHK("deny", !g, rsp.deny)
		`CHK("rdata", d, rsp.rdata)
		`CHK("erase", o == fbep_pkg::FBEP_OP_ERASE && g, arr_erase)
		`CHK("erase_unit", a[16:10], (o == fbep_pkg::FBEP_OP_ERASE && g) ? arr_erase_unit : a[16:10])
		`CHK("prog", o == fbep_pkg::FBEP_OP_PROG && g, arr_prog)
	endtask : acc
	task automatic t_open;
		acc(fbep_pkg::FBEP_OP_PROG, 17'h00C04, 32'h5A5A1234, 1, 0);
		acc(fbep_pkg::FBEP_OP_DBGREAD, 17'h00C04, 0, 1, 32'h5A5A1234);
		acc(fbep_pkg::FBEP_OP_ERASE, 17'h00C00, 0, 1, 0);
		acc(fbep_pkg::FBEP_OP_DREAD, 17'h00C04, 0, 1, 32'hFFFFFFFF);
		acc(fbep_pkg::FBEP_OP_FETCH, 17'h00800, 0, 1, 32'h00000200);
	endtask : t_open
	task automatic t_ro;
		@(posedge clk);
		ro_bits <= 64'h2;
		acc(fbep_pkg::FBEP_OP_ERASE, 17'h00800, 0, 0, 0);
		acc(fbep_pkg::FBEP_OP_DREAD, 17'h00800, 0, 1, 32'h00000200);
		acc(fbep_pkg::FBEP_OP_PROG, 17'h00C04, 32'h0, 0, 0);
		acc(fbep_pkg::FBEP_OP_DREAD, 17'h00C04, 0, 1, 32'hFFFFFFFF);
		acc(fbep_pkg::FBEP_OP_ERASE, 17'h01000, 0, 1, 0);
		@(posedge clk);
		ro_bits <= 64'h0;
	endtask : t_ro
	task automatic t_xo;
		@(posedge clk);
		xo_bits <= 64'h2;
		acc(fbep_pkg::FBEP_OP_FETCH, 17'h00C04, 0, 1, 32'hFFFFFFFF);
		acc(fbep_pkg::FBEP_OP_DREAD, 17'h00C04, 0, 0, 0);
		acc(fbep_pkg::FBEP_OP_DBGREAD, 17'h00804, 0, 0, 0);
		acc(fbep_pkg::FBEP_OP_ERASE, 17'h00C00, 0, 0, 0);
		acc(fbep_pkg::FBEP_OP_PROG, 17'h00800, 32'h0, 0, 0);
		acc(fbep_pkg::FBEP_OP_FETCH, 17'h00800, 0, 1, 32'h00000200);
		acc(fbep_pkg::FBEP_OP_DREAD, 17'h01004, 0, 1, 32'hFFFFFFFF);
	endtask : t_xo
	// reset in mid-run swallows a pending erase and keeps the strobes quiet
	task automatic t_reset;
		@(posedge clk);
		rst       <= 1'b1;
		req_valid <= 1'b1;
		req       <= '{op: fbep_pkg::FBEP_OP_ERASE, addr: 17'h01800, wdata: 32'h0};
		@(posedge clk);
		req_valid <= 1'b0;
		#1;
		`CHK("rst_rsp_valid", 1'b0, rsp_valid)
		`CHK("rst_erase", 1'b0, arr_erase)
		@(posedge clk);
		rst <= 1'b0;
		acc(fbep_pkg::FBEP_OP_FETCH, 17'h01800, 0, 1, 32'h00000600);
	endtask : t_reset
	task automatic report_and_stop;
		if (n_errors == 0 && n_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : report_and_stop
	initial begin
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		t_open();
		t_ro();
		t_xo();
		t_reset();
		report_and_stop();
	end
endmodule : testbench
`default_nettype wire
